/* adc_setup_and_mode_config_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// [RULE1] Per-setup 24-bit gain, setup 0 at 0x38
// [RULE2] Gain loads factory trim at reset
// [RULE3] Gain replaced by write or full-scale cal
// [RULE4] Per-setup offset resets 0x800000, at 0x30
// [RULE5] Offset replaced by write or zero cal
// [RULE6] Mode selects conversion, standby, power, cal
// [RULE7] Mode holds clock select, reference enable
// [RULE8] Converter mode 16 bits, 0x01, 0x8000
// [RULE9] Interface mode sets word, checksum, status, read
// [RULE10] Interface mode 16 bits, 0x02, 0x0000
// [RULE11] Setup config 0 at 0x20, 0x1320
// [RULE12] Filter config 0 at 0x28, 0x0500
// [RULE13] Four setups, any channel any setup
// [RULE14] Host may leave coefficients unprogrammed
// [RULE15] Channel converts only when enable set
// [RULE16] Sequencer ascends then wraps to lowest
// [RULE17] Four identical register sets per setup
// [RULE18] Bipolar offset binary, unipolar straight binary
// [RULE19] Sequencer skips disabled channels
// [RULE20] Reserved bits read zero, writes ignored
module adc_setup_and_mode_config_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [23:0] reg_wdata_i,
    output logic [23:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_hit_o,
    input wire logic [3:0][23:0] factory_gain_i,
    input wire logic conv_done_i,
    input wire logic [23:0] raw_result_i,
    input wire logic cal_done_i,
    input wire logic [23:0] cal_coeff_i,
    output cfg_regs_pkg::converter_ctl_t converter_ctl_o,
    output logic [15:0] interface_mode_o,
    output logic converting_o,
    output logic [1:0] active_channel_o,
    output logic [15:0] active_channel_cfg_o,
    output cfg_regs_pkg::setup_t active_setup_o,
    output logic [23:0] result_o,
    output logic [1:0] result_channel_o,
    output logic result_valid_o
);

    // ------------
    // Storage
    // ------------
    logic [15:0] converter_mode;
    logic [15:0] interface_mode;
    logic [15:0] channel_reg [cfg_regs_pkg::NUM_CHANNELS];
    logic [15:0] setup_cfg [cfg_regs_pkg::NUM_SETUPS];
    logic [15:0] filter_cfg [cfg_regs_pkg::NUM_SETUPS];
    logic [23:0] offset_coeff [cfg_regs_pkg::NUM_SETUPS];
    logic [23:0] gain_coeff [cfg_regs_pkg::NUM_SETUPS];

    logic [3:0] enable_mask;
    logic [1:0] seq_channel;
    logic any_enabled;
    logic [1:0] active_setup_sel;
    logic [2:0] mode;
    logic running;
    logic cal_mode;
    logic cal_write_gain;
    logic cal_write_offset;
    logic [23:0] coded;
    logic [15:0] next_converter_mode;

    // ------------
    // Address decode helpers
    // ------------
    // Matches a four-entry block, returns its index
    function automatic logic block_hit(
        input logic [5:0] addr,
        input logic [5:0] base
    );
        block_hit = (addr[5:2] == base[5:2]) && !addr[2];
    endfunction

    function automatic logic [1:0] block_index(input logic [5:0] addr);
        block_index = addr[1:0];
    endfunction

    // ------------
    // Mode decode
    // ------------
    // [RULE6] Mode field picks operation
    assign mode = converter_mode[cfg_regs_pkg::CM_MODE_LSB +: 3];
    assign running = (mode == cfg_regs_pkg::MODE_CONTINUOUS) ||
                     (mode == cfg_regs_pkg::MODE_SINGLE);
    assign cal_mode = (mode == cfg_regs_pkg::MODE_INT_ZERO_CAL) ||
                      (mode == cfg_regs_pkg::MODE_SYS_ZERO_CAL) ||
                      (mode == cfg_regs_pkg::MODE_SYS_FULL_CAL);
    assign converting_o = (running || cal_mode) && any_enabled;

    // [RULE3] Full-scale cal completion
    assign cal_write_gain = cal_done_i &&
        (mode == cfg_regs_pkg::MODE_SYS_FULL_CAL);
    // [RULE5] Internal or system zero cal
    assign cal_write_offset = cal_done_i &&
        ((mode == cfg_regs_pkg::MODE_INT_ZERO_CAL) ||
         (mode == cfg_regs_pkg::MODE_SYS_ZERO_CAL));

    // ------------
    // Channel enables and sequencing
    // ------------
    genvar g;
    generate
        for (g = 0; g < cfg_regs_pkg::NUM_CHANNELS; g++) begin : g_en
            // [RULE15] Enable is channel MSB
            assign enable_mask[g] = channel_reg[g][cfg_regs_pkg::CH_EN_BIT];
        end
    endgenerate

    // Only continuous mode steps on a result; every mode moves off a disabled channel
    channel_sequencer i_channel_sequencer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .enable_mask_i(enable_mask),
        .advance_i(conv_done_i && converting_o &&
                   (mode == cfg_regs_pkg::MODE_CONTINUOUS)),
        .channel_o(seq_channel),
        .any_enabled_o(any_enabled)
    );

    assign active_channel_o = seq_channel;
    assign active_channel_cfg_o = channel_reg[seq_channel];

    // [RULE13] Channel picks any of four setups
    assign active_setup_sel =
        channel_reg[seq_channel][cfg_regs_pkg::CH_SETUP_LSB +: 2];
    assign active_setup_o = '{
        setup_cfg: setup_cfg[active_setup_sel],
        filter_cfg: filter_cfg[active_setup_sel],
        offset: offset_coeff[active_setup_sel],
        gain: gain_coeff[active_setup_sel]
    };

    // ------------
    // Converter mode register
    // ------------
    always_comb begin
        next_converter_mode = converter_mode;
        // [RULE20] Masked write
        if (reg_wr_i && reg_addr_i == cfg_regs_pkg::ADDR_CONVERTER_MODE) begin
            next_converter_mode = reg_wdata_i[15:0] &
                                  cfg_regs_pkg::MASK_CONVERTER_MODE;
        end
        // Single conversion and calibration end in standby
        if ((conv_done_i && mode == cfg_regs_pkg::MODE_SINGLE &&
             converting_o) || (cal_done_i && cal_mode)) begin
            next_converter_mode[cfg_regs_pkg::CM_MODE_LSB +: 3] =
                cfg_regs_pkg::MODE_STANDBY;
        end
    end

    // [RULE8] Converter mode reset value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_mode <= cfg_regs_pkg::RST_CONVERTER_MODE;
        end else if (ce_i) begin
            converter_mode <= next_converter_mode;
        end
    end

    // [RULE7] Clock source and reference enable
    assign converter_ctl_o = '{
        ref_enable: converter_mode[cfg_regs_pkg::CM_REF_EN],
        suppress_settle_delay: converter_mode[cfg_regs_pkg::CM_HIDE],
        single_cycle_settling: converter_mode[cfg_regs_pkg::CM_SING],
        delay: converter_mode[cfg_regs_pkg::CM_DELAY_LSB +: 3],
        mode: mode,
        clock_source_select: converter_mode[cfg_regs_pkg::CM_CLK_LSB +: 2]
    };

    // ------------
    // Interface mode register
    // ------------
    // [RULE10] Interface mode at 0x02
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            interface_mode <= cfg_regs_pkg::RST_INTERFACE_MODE;
        end else if (ce_i && reg_wr_i &&
                     reg_addr_i == cfg_regs_pkg::ADDR_INTERFACE_MODE) begin
            // [RULE9] Word, checksum, status, read
            interface_mode <= reg_wdata_i[15:0] &
                              cfg_regs_pkg::MASK_INTERFACE_MODE;
        end
    end

    assign interface_mode_o = interface_mode;

    // ------------
    // Channel registers
    // ------------
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < cfg_regs_pkg::NUM_CHANNELS; i++) begin
            if (rst_i) begin
                channel_reg[i] <= (i == 0) ? cfg_regs_pkg::RST_CHANNEL_ZERO
                                           : cfg_regs_pkg::RST_CHANNEL_OTHER;
            end else if (ce_i && reg_wr_i &&
                         block_hit(reg_addr_i,
                                   cfg_regs_pkg::ADDR_CHANNEL_BASE) &&
                         block_index(reg_addr_i) == 2'(i)) begin
                channel_reg[i] <= reg_wdata_i[15:0] &
                                  cfg_regs_pkg::MASK_CHANNEL;
            end
        end
    end

    // ------------
    // Setup and filter configuration
    // ------------
    // [RULE17] Identical set per setup
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < cfg_regs_pkg::NUM_SETUPS; i++) begin
            if (rst_i) begin
                // [RULE11] Setup config reset
                setup_cfg[i] <= cfg_regs_pkg::RST_SETUP_CFG;
                // [RULE12] Filter config reset
                filter_cfg[i] <= cfg_regs_pkg::RST_FILTER_CFG;
            end else if (ce_i && reg_wr_i &&
                         block_index(reg_addr_i) == 2'(i)) begin
                if (block_hit(reg_addr_i,
                              cfg_regs_pkg::ADDR_SETUP_CFG_BASE)) begin
                    setup_cfg[i] <= reg_wdata_i[15:0] &
                                    cfg_regs_pkg::MASK_SETUP_CFG;
                end
                if (block_hit(reg_addr_i,
                              cfg_regs_pkg::ADDR_FILTER_CFG_BASE)) begin
                    filter_cfg[i] <= reg_wdata_i[15:0] &
                                     cfg_regs_pkg::MASK_FILTER_CFG;
                end
            end
        end
    end

    // ------------
    // Offset coefficients
    // ------------
    // Cal result wins over a host write in the same cycle
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < cfg_regs_pkg::NUM_SETUPS; i++) begin
            if (rst_i) begin
                // [RULE4] Offset reset value
                offset_coeff[i] <= cfg_regs_pkg::RST_OFFSET;
            end else if (ce_i) begin
                if (cal_write_offset && active_setup_sel == 2'(i)) begin
                    // [RULE5] Zero cal overwrite
                    offset_coeff[i] <= cal_coeff_i;
                end else if (reg_wr_i && block_index(reg_addr_i) == 2'(i) &&
                             block_hit(reg_addr_i,
                                       cfg_regs_pkg::ADDR_OFFSET_BASE)) begin
                    offset_coeff[i] <= reg_wdata_i;
                end
            end
        end
    end

    // ------------
    // Gain coefficients
    // ------------
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < cfg_regs_pkg::NUM_SETUPS; i++) begin
            if (rst_i) begin
                // [RULE2] Factory trim at reset
                gain_coeff[i] <= factory_gain_i[i];
            end else if (ce_i) begin
                if (cal_write_gain && active_setup_sel == 2'(i)) begin
                    // [RULE3] Full-scale cal overwrite
                    gain_coeff[i] <= cal_coeff_i;
                end else if (reg_wr_i && block_index(reg_addr_i) == 2'(i) &&
                             block_hit(reg_addr_i,
                                       cfg_regs_pkg::ADDR_GAIN_BASE)) begin
                    gain_coeff[i] <= reg_wdata_i;
                end
            end
        end
    end

    // ------------
    // Register read
    // ------------
    // [RULE1] Readable coefficient window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 24'h000000;
            reg_rvalid_o <= 1'b0;
            reg_hit_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            reg_hit_o <= 1'b1;
            // [RULE20] Unmapped and reserved read zero
            reg_rdata_o <= 24'h000000;
            if (reg_rd_i) begin
                if (reg_addr_i == cfg_regs_pkg::ADDR_CONVERTER_MODE) begin
                    reg_rdata_o <= {8'h00, converter_mode};
                end else if (reg_addr_i ==
                             cfg_regs_pkg::ADDR_INTERFACE_MODE) begin
                    reg_rdata_o <= {8'h00, interface_mode};
                end else if (reg_addr_i == cfg_regs_pkg::ADDR_ID) begin
                    reg_rdata_o <= {8'h00, cfg_regs_pkg::ID_VALUE};
                end else if (block_hit(reg_addr_i,
                                       cfg_regs_pkg::ADDR_CHANNEL_BASE)) begin
                    reg_rdata_o <= {8'h00,
                                    channel_reg[block_index(reg_addr_i)]};
                end else if (block_hit(reg_addr_i,
                                   cfg_regs_pkg::ADDR_SETUP_CFG_BASE)) begin
                    reg_rdata_o <= {8'h00,
                                    setup_cfg[block_index(reg_addr_i)]};
                end else if (block_hit(reg_addr_i,
                                   cfg_regs_pkg::ADDR_FILTER_CFG_BASE)) begin
                    reg_rdata_o <= {8'h00,
                                    filter_cfg[block_index(reg_addr_i)]};
                end else if (block_hit(reg_addr_i,
                                       cfg_regs_pkg::ADDR_OFFSET_BASE)) begin
                    reg_rdata_o <= offset_coeff[block_index(reg_addr_i)];
                end else if (block_hit(reg_addr_i,
                                       cfg_regs_pkg::ADDR_GAIN_BASE)) begin
                    reg_rdata_o <= gain_coeff[block_index(reg_addr_i)];
                end else begin
                    reg_hit_o <= 1'b0;
                end
            end
        end
    end

    // ------------
    // Result coding
    // ------------
    result_coder i_result_coder (
        .raw_i(raw_result_i),
        .bipolar_i(active_setup_o.setup_cfg[cfg_regs_pkg::SC_POLARITY_BIT]),
        .coded_o(coded)
    );

    // Calibration cycles produce no result word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_o <= 24'h000000;
            result_channel_o <= 2'h0;
            result_valid_o <= 1'b0;
        end else if (ce_i) begin
            // [RULE15] Report only while any channel is enabled
            result_valid_o <= conv_done_i && running && any_enabled;
            if (conv_done_i && running && any_enabled) begin
                result_o <= coded;
                result_channel_o <= seq_channel;
            end
        end
    end

endmodule
`default_nettype wire

/* adc_setup_and_mode_config_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_setup_and_mode_config_regs_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic conv_done_i = 1'b0;
    logic cal_done_i = 1'b0;
    logic [23:0] raw_result_i = 24'h000000;
    logic [23:0] cal_coeff_i = 24'h000000;
    logic [3:0][23:0] factory_gain_i = {24'h5A0003, 24'h5A0002,
        24'h5A0001, 24'h5A0000};
    logic [5:0] reg_addr;
    logic reg_wr, reg_rd, reg_hit, result_valid_o, rd_hit;
    logic [23:0] reg_wdata, reg_rdata, result_o, rd_data;
    logic [1:0] result_channel_o;
    logic [15:0] if_mode, ch_cfg;
    int num_errors = 0;
    int checks_done = 0;
    always #10 clk_i = ~clk_i;
    host_model i_host_model (.clk_i(clk_i), .reg_addr_o(reg_addr),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata),
        .reg_rdata_i(reg_rdata), .reg_hit_i(reg_hit));
    adc_setup_and_mode_config_regs i_adc_setup_and_mode_config_regs (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .reg_rvalid_o(), .reg_hit_o(reg_hit),
        .factory_gain_i(factory_gain_i), .conv_done_i(conv_done_i),
        .raw_result_i(raw_result_i), .cal_done_i(cal_done_i),
        .cal_coeff_i(cal_coeff_i), .converter_ctl_o(),
        .interface_mode_o(if_mode), .converting_o(), .active_channel_o(),
        .active_channel_cfg_o(ch_cfg), .active_setup_o(), .result_o(result_o),
        .result_channel_o(result_channel_o), .result_valid_o(result_valid_o));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [23:0] exp);
        i_host_model.rd(a, rd_data, rd_hit);
        chk(rd_data, exp);
        chk({23'h000000, rd_hit}, 24'h000001);
    endtask
    task automatic conv(input logic [23:0] raw, input logic [1:0] ch,
        input logic [23:0] exp);
        @(posedge clk_i);
        conv_done_i <= 1'b1;
        raw_result_i <= raw;
        @(posedge clk_i);
        conv_done_i <= 1'b0;
        raw_result_i <= ~raw;
        #1;
        chk({23'h000000, result_valid_o}, 24'h000001);
        chk({22'h000000, result_channel_o}, {22'h000000, ch});
        chk(result_o, exp);
    endtask
    task automatic cal(input logic [23:0] m, input logic [23:0] c);
        i_host_model.wr(6'h01, m);
        @(posedge clk_i);
        cal_done_i <= 1'b1;
        cal_coeff_i <= c;
        @(posedge clk_i);
        cal_done_i <= 1'b0;
        cal_coeff_i <= ~c;
    endtask
    task automatic t_reset;
        rchk(6'h01, 24'h008000);
        rchk(6'h02, 24'h000000);
        for (int i = 0; i < 4; i++) begin
            rchk(6'h20 + 6'(i), 24'h001320);
            rchk(6'h28 + 6'(i), 24'h000500);
            rchk(6'h30 + 6'(i), 24'h800000);
            rchk(6'h38 + 6'(i), factory_gain_i[i]);
        end
        i_host_model.rd(6'h3F, rd_data, rd_hit);
        chk(rd_data, 24'h000000);
        chk({23'h000000, rd_hit}, 24'h000000);
    endtask
    task automatic t_rw;
        i_host_model.wr(6'h01, 24'hFFFFFF);
        rchk(6'h01, 24'h00E77C);
        i_host_model.wr(6'h02, 24'hFFFFFF);
        rchk(6'h02, 24'h0019ED);
        chk({8'h00, if_mode}, 24'h0019ED);
        i_host_model.wr(6'h21, 24'hFFFFFF);
        rchk(6'h21, 24'h001FB0);
        i_host_model.wr(6'h29, 24'hFFFFFF);
        rchk(6'h29, 24'h008F7F);
        i_host_model.wr(6'h32, 24'h123456);
        rchk(6'h32, 24'h123456);
        i_host_model.wr(6'h3A, 24'h654321);
        rchk(6'h3A, 24'h654321);
        i_host_model.wr(6'h01, 24'h008000);
        i_host_model.wr(6'h21, 24'h000320);
    endtask
    task automatic t_seq;
        i_host_model.wr(6'h12, 24'h009001);
        conv(24'h000010, 2'h0, 24'h800010);
        chk({8'h00, ch_cfg}, 24'h009001);
        conv(24'h100000, 2'h2, 24'h200000);
        conv(24'hFFFFFF, 2'h0, 24'h7FFFFF);
    endtask
    task automatic t_cal;
        i_host_model.wr(6'h01, 24'h008010);
        conv(24'h000004, 2'h2, 24'h000008);
        rchk(6'h01, 24'h008020);
        cal(24'h008040, 24'h0A0B0C);
        rchk(6'h31, 24'h0A0B0C);
        cal(24'h008070, 24'h0C0B0A);
        rchk(6'h39, 24'h0C0B0A);
        rchk(6'h38, 24'h5A0000);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_rw;
        t_seq;
        t_cal;
        wrap_up;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        num_errors++;
        wrap_up;
    end
endmodule
`default_nettype wire

/* cfg_regs_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module cfg_regs_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [23:0] reg_wdata_i,
    input wire logic [23:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic conv_done_i,
    input wire logic [23:0] raw_result_i,
    input wire logic cal_done_i,
    input wire logic [23:0] cal_coeff_i,
    input wire cfg_regs_pkg::converter_ctl_t converter_ctl_o,
    input wire logic converting_o,
    input wire logic [1:0] active_channel_o,
    input wire cfg_regs_pkg::setup_t active_setup_o,
    input wire logic [23:0] result_o,
    input wire logic [1:0] result_channel_o,
    input wire logic result_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_read;
        reg_rd_i && ce_i;
    endsequence
    sequence s_conv;
        conv_done_i && ce_i && converting_o;
    endsequence
    property p_read;
        s_read |=> reg_rvalid_o;
    endproperty
    property p_quiet;
        !reg_rd_i && ce_i |=> !reg_rvalid_o;
    endproperty
    property p_mode_rsvd;
        reg_rvalid_o && $past(reg_addr_i) == 6'h01 |->
            (reg_rdata_o & ~24'h00E77C) == 24'h000000;
    endproperty
    property p_ref_en;
        reg_wr_i && ce_i && reg_addr_i == 6'h01 |=>
            converter_ctl_o.ref_enable == $past(reg_wdata_i[15]);
    endproperty
    property p_result;
        s_conv ##0 converter_ctl_o.mode <= 3'h1 |=> result_valid_o;
    endproperty
    property p_no_result;
        !conv_done_i && ce_i |=> !result_valid_o;
    endproperty
    property p_single;
        s_conv ##0 converter_ctl_o.mode == 3'h1 |=> converter_ctl_o.mode == 3'h2;
    endproperty
    property p_chan;
        result_valid_o |-> result_channel_o == $past(active_channel_o);
    endproperty
    property p_bipolar;
        result_valid_o && $past(active_setup_o.setup_cfg[12]) |->
            result_o == {~$past(raw_result_i[23]), $past(raw_result_i[22:0])};
    endproperty
    property p_offcal;
        cal_done_i && ce_i && converting_o && converter_ctl_o.mode == 3'h4
            |=> active_setup_o.offset == $past(cal_coeff_i);
    endproperty
    a_read: assert property (p_read) else $error("no read answer");
    a_quiet: assert property (p_quiet) else $error("stray answer");
    a_mode_rsvd: assert property (p_mode_rsvd) else $error("rsvd set");
    a_ref_en: assert property (p_ref_en) else $error("ref enable");
    a_result: assert property (p_result) else $error("no result");
    a_no_result: assert property (p_no_result) else $error("stray");
    a_single: assert property (p_single) else $error("no standby");
    a_chan: assert property (p_chan) else $error("bad channel");
    a_bipolar: assert property (p_bipolar) else $error("coding");
    a_offcal: assert property (p_offcal) else $error("offset cal");
endmodule
bind adc_setup_and_mode_config_regs cfg_regs_checker i_cfg_regs_checker (.*);
`default_nettype wire

/* cfg_regs_pkg.sv */
`default_nettype none
package cfg_regs_pkg;

    // ------------
    // Register addresses (six-bit register index)
    // ------------
    localparam logic [5:0] ADDR_CONVERTER_MODE = 6'h01;
    localparam logic [5:0] ADDR_INTERFACE_MODE = 6'h02;
    localparam logic [5:0] ADDR_ID = 6'h07;
    localparam logic [5:0] ADDR_CHANNEL_BASE = 6'h10;
    localparam logic [5:0] ADDR_SETUP_CFG_BASE = 6'h20;
    localparam logic [5:0] ADDR_FILTER_CFG_BASE = 6'h28;
    localparam logic [5:0] ADDR_OFFSET_BASE = 6'h30;
    localparam logic [5:0] ADDR_GAIN_BASE = 6'h38;

    // ------------
    // Counts
    // ------------
    localparam int NUM_SETUPS = 4;
    localparam int NUM_CHANNELS = 4;

    // ------------
    // Reset values
    // ------------
    localparam logic [15:0] RST_CONVERTER_MODE = 16'h8000;
    localparam logic [15:0] RST_INTERFACE_MODE = 16'h0000;
    localparam logic [15:0] RST_CHANNEL_ZERO = 16'h8001;
    localparam logic [15:0] RST_CHANNEL_OTHER = 16'h0001;
    localparam logic [15:0] RST_SETUP_CFG = 16'h1320;
    localparam logic [15:0] RST_FILTER_CFG = 16'h0500;
    localparam logic [23:0] RST_OFFSET = 24'h800000;

    // Arbitrary identification value
    localparam logic [15:0] ID_VALUE = 16'h0A50;

    // ------------
    // Writable bit masks, reserved bits cleared
    // ------------
    localparam logic [15:0] MASK_CONVERTER_MODE = 16'hE77C;
    localparam logic [15:0] MASK_INTERFACE_MODE = 16'h19ED;
    localparam logic [15:0] MASK_CHANNEL = 16'hB3FF;
    localparam logic [15:0] MASK_SETUP_CFG = 16'h1FB0;
    localparam logic [15:0] MASK_FILTER_CFG = 16'h8F7F;

    // ------------
    // Field positions
    // ------------
    localparam int CM_REF_EN = 15;
    localparam int CM_HIDE = 14;
    localparam int CM_SING = 13;
    localparam int CM_DELAY_LSB = 8;
    localparam int CM_MODE_LSB = 4;
    localparam int CM_CLK_LSB = 2;
    localparam int CH_EN_BIT = 15;
    localparam int CH_SETUP_LSB = 12;
    localparam int SC_POLARITY_BIT = 12;

    // ------------
    // Operating mode codes
    // ------------
    localparam logic [2:0] MODE_CONTINUOUS = 3'h0;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_STANDBY = 3'h2;
    localparam logic [2:0] MODE_POWER_DOWN = 3'h3;
    localparam logic [2:0] MODE_INT_ZERO_CAL = 3'h4;
    localparam logic [2:0] MODE_SYS_ZERO_CAL = 3'h6;
    localparam logic [2:0] MODE_SYS_FULL_CAL = 3'h7;

    // ------------
    // Carriers
    // ------------
    typedef struct packed {
        logic ref_enable;
        logic suppress_settle_delay;
        logic single_cycle_settling;
        logic [2:0] delay;
        logic [2:0] mode;
        logic [1:0] clock_source_select;
    } converter_ctl_t;

    typedef struct packed {
        logic [15:0] setup_cfg;
        logic [15:0] filter_cfg;
        logic [23:0] offset;
        logic [23:0] gain;
    } setup_t;

endpackage
`default_nettype wire

/* channel_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module channel_sequencer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [3:0] enable_mask_i,
    input wire logic advance_i,
    output logic [1:0] channel_o,
    output logic any_enabled_o
);

    // Next enabled channel above cur, wrapping to the lowest
    function automatic logic [1:0] next_enabled(
        input logic [3:0] mask,
        input logic [1:0] cur
    );
        logic [1:0] idx;
        logic found;
        next_enabled = cur;
        found = 1'b0;
        for (int i = 1; i <= 4; i++) begin
            idx = 2'(cur + 2'(i));
            if (!found && mask[idx]) begin
                next_enabled = idx;
                found = 1'b1;
            end
        end
    endfunction

    assign any_enabled_o = |enable_mask_i;

    // [RULE16] Ascending order, wrap
    // [RULE19] Disabled channels skipped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_o <= 2'h0;
        end else if (ce_i) begin
            if (advance_i || !enable_mask_i[channel_o]) begin
                channel_o <= next_enabled(enable_mask_i, channel_o);
            end
        end
    end

endmodule
`default_nettype wire

/* host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic clk_i,
    output logic [5:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [23:0] reg_wdata_o,
    input wire logic [23:0] reg_rdata_i,
    input wire logic reg_hit_i
);
    initial begin
        reg_addr_o = 6'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 24'h000000;
    end
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic h);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        #1;
        d = reg_rdata_i;
        h = reg_hit_i;
    endtask
endmodule
`default_nettype wire

/* result_coder.sv */
`timescale 1ns/1ns
`default_nettype none
module result_coder (
    input wire logic [23:0] raw_i,
    input wire logic bipolar_i,
    output logic [23:0] coded_o
);

    // [RULE18] Offset or straight binary
    always_comb begin
        if (bipolar_i) begin
            coded_o = {~raw_i[23], raw_i[22:0]};
        end else if (raw_i[23]) begin
            // Unipolar cannot show negative inputs
            coded_o = 24'h000000;
        end else begin
            coded_o = {raw_i[22:0], 1'b0};
        end
    end

endmodule
`default_nettype wire
